// ==== src/ep_fifo.sv ====
`timescale 1ns/10ps
module ep_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_in,
  input wire logic rst_in,
  fifo_if.store port
);
  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  // DEPTH must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] level_q;
  logic [W-1:0] rdata_q;
  logic do_push;
  logic do_pop;

  assign port.empty = (level_q == '0);
  assign port.full = (level_q == FULL_LEVEL);
  assign port.rdata = rdata_q;
  assign do_push = port.push & ~port.full;
  assign do_pop = port.pop & ~port.empty;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wptr_q] <= port.wdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (do_push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (do_pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= '0;
    end else if (do_push && !do_pop) begin
      level_q <= level_q + 1'b1;
    end else if (do_pop && !do_push) begin
      level_q <= level_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (do_pop) begin
      rdata_q <= mem[rptr_q];
    end
  end

  a_push_step: assert property (@(posedge clk_in) disable iff (rst_in)
    do_push |=> wptr_q == $past(wptr_q) + 1'b1) else $error("write pointer did not step");
  a_pop_step: assert property (@(posedge clk_in) disable iff (rst_in)
    do_pop |=> (rptr_q == $past(rptr_q) + 1'b1) && (rdata_q == $past(mem[rptr_q])))
    else $error("read pointer did not step");
endmodule

// ==== src/fifo_if.sv ====
`timescale 1ns/10ps
interface fifo_if #(parameter int W = 8);
  logic push;
  logic pop;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic empty;
  logic full;
  modport ctrl(output push, output pop, output wdata, input rdata, input empty, input full);
  modport store(input push, input pop, input wdata, output rdata, output empty, output full);
endinterface

// ==== src/rx_counter.sv ====
`timescale 1ns/10ps
module rx_counter #(
  parameter int CNT_W = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic pid_in,
  output logic [CNT_W-1:0] count_out
);
  logic [CNT_W-1:0] count_q;

  // ---------------------------------------------------------------
  // Data bytes after the PID byte
  // ---------------------------------------------------------------
  // Saturates rather than wraps so an oversize packet never looks short
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else if (valid_in && pid_in) begin
      count_q <= '0;
    end else if (valid_in && count_q != '1) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign count_out = count_q;

  a_pid_excluded: assert property (@(posedge clk_in) disable iff (rst_in)
    (valid_in && pid_in) ##1 (valid_in && !pid_in) |=> count_q == 1) else $error("PID byte was counted");
endmodule

// ==== src/usb_ep_access.sv ====
`timescale 1ns/10ps
// Contract
// - Software data-register write pushes the byte into the selected endpoint's FIFO.
// - Software data-register read returns a byte popped from the selected endpoint's FIFO.
// - Data and both count registers are indexed by the endpoint-number field.
// - Low count register shows count bits 7..0 of last packet on selected endpoint.
// - Count equals data bytes after the Data PID, PID itself excluded.
// - High count register shows upper count bits in its lowest positions.
// - Reserved upper bits of the high count register always read zero.
module usb_ep_access #(
  parameter int NUM_EP = usb_ep_pkg::NUM_EP,
  parameter int FIFO_DEPTH = usb_ep_pkg::FIFO_DEPTH,
  parameter int CNT_W = usb_ep_pkg::CNT_W
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [11:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [11:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic USB_RX_VALID_IN,
  input wire logic USB_RX_PID_IN,
  input wire logic [7:0] USB_RX_DATA_IN,
  input wire logic [2:0] USB_RX_EP_IN,
  input wire logic USB_RX_EOP_IN,
  input wire logic USB_TX_POP_IN,
  input wire logic [2:0] USB_TX_EP_IN,
  output logic [7:0] USB_TX_DATA_OUT,
  output logic USB_TX_VALID_OUT,
  output logic [NUM_EP-1:0] USB_FIFO_EMPTY_OUT
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [2:0] sel_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  usb_ep_pkg::rd_state_t rd_state_q;
  logic [11:0] araddr_q;
  logic [2:0] rd_ep_q;
  logic rd_empty_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rx_active_q;
  logic [2:0] rx_ep_q;
  logic [2:0] tx_ep_q;
  logic tx_pend_q;
  logic [7:0] tx_data_q;
  logic [CNT_W-1:0] cnt_q [NUM_EP];
  logic [CNT_W-1:0] rx_count;
  logic [NUM_EP-1:0] usb_push;
  logic [NUM_EP-1:0] usb_pop;
  logic [NUM_EP-1:0] fifo_push;
  logic [NUM_EP-1:0] fifo_empty;
  logic [7:0] fifo_rdata [NUM_EP];
  logic rx_data;
  logic wr_go;
  logic wr_block;
  logic rd_block;
  logic sw_push;
  logic sw_pop;
  logic ar_take;
  logic [7:0] fifo_rdata_sel;
  logic [CNT_W-1:0] cnt_sel;
  logic sel_ok;
  logic rd_ep_ok;

  // ---------------------------------------------------------------
  // Endpoint FIFOs
  // ---------------------------------------------------------------
  assign rx_data = USB_RX_VALID_IN & ~USB_RX_PID_IN & rx_active_q;

  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    fifo_if #(.W(8)) f ();
    assign usb_push[e] = rx_data & (rx_ep_q == 3'(e));
    assign usb_pop[e] = USB_TX_POP_IN & (USB_TX_EP_IN == 3'(e));
    assign f.push = usb_push[e] | (sw_push & (sel_q == 3'(e)));
    assign f.wdata = usb_push[e] ? USB_RX_DATA_IN : wdata_q;
    assign f.pop = usb_pop[e] | (sw_pop & (rd_ep_q == 3'(e)));
    assign fifo_push[e] = f.push;
    assign fifo_empty[e] = f.empty;
    assign fifo_rdata[e] = f.rdata;
    ep_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .port(f.store)
    );
  end

  assign USB_FIFO_EMPTY_OUT = fifo_empty;
  // Code 7 names no endpoint: keep out-of-range indexing from spreading unknowns
  assign sel_ok = (int'(sel_q) < NUM_EP);
  assign rd_ep_ok = (int'(rd_ep_q) < NUM_EP);
  assign fifo_rdata_sel = fifo_rdata[rd_ep_q];
  assign cnt_sel = rd_ep_ok ? cnt_q[rd_ep_q] : '0;

  // ---------------------------------------------------------------
  // Receive side: PID latches endpoint, end of packet stores count
  // ---------------------------------------------------------------
  rx_counter #(.CNT_W(CNT_W)) u_count (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .valid_in(USB_RX_VALID_IN),
    .pid_in(USB_RX_PID_IN),
    .count_out(rx_count)
  );

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_active_q <= 1'b0;
      rx_ep_q <= 3'h0;
    end else if (USB_RX_VALID_IN && USB_RX_PID_IN) begin
      rx_active_q <= 1'b1;
      rx_ep_q <= USB_RX_EP_IN;
    end else if (USB_RX_EOP_IN) begin
      rx_active_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < NUM_EP; i++) begin
        cnt_q[i] <= '0;
      end
    end else if (USB_RX_EOP_IN && rx_active_q) begin
      cnt_q[rx_ep_q] <= rx_count;
    end
  end

  // ---------------------------------------------------------------
  // Transmit side: valid rises one cycle after the pop, byte appears one cycle after that
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_ep_q <= 3'h0;
      tx_pend_q <= 1'b0;
      tx_data_q <= usb_ep_pkg::FIFO_DATA_RESET;
    end else begin
      tx_pend_q <= USB_TX_POP_IN & ~fifo_empty[USB_TX_EP_IN];
      tx_ep_q <= USB_TX_EP_IN;
      if (tx_pend_q) begin
        tx_data_q <= fifo_rdata[tx_ep_q];
      end
    end
  end

  assign USB_TX_DATA_OUT = tx_data_q;
  assign USB_TX_VALID_OUT = tx_pend_q;

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // USB traffic on the same endpoint wins; software waits until that traffic stops
  assign wr_block = (awaddr_q == usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA) & sel_ok & (usb_push[sel_q] | usb_pop[sel_q]);
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q & ~wr_block;
  assign sw_push = wr_go & (awaddr_q == usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA) & wstrb0_q;
  assign AXI_AWREADY_OUT = ~aw_hold_q & ~bvalid_q;
  assign AXI_WREADY_OUT = ~w_hold_q & ~bvalid_q;
  assign AXI_BVALID_OUT = bvalid_q;
  assign AXI_BRESP_OUT = bresp_q;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= AXI_AWADDR_IN;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      w_hold_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      w_hold_q <= 1'b1;
      wdata_q <= AXI_WDATA_IN[7:0];
      wstrb0_q <= AXI_WSTRB_IN[0];
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_q <= usb_ep_pkg::ENDPOINT_SELECT_RESET;
    end else if (wr_go && wstrb0_q && awaddr_q == usb_ep_pkg::ADDR_ENDPOINT_SELECT) begin
      sel_q <= wdata_q[usb_ep_pkg::ENDPOINT_NUMBER_FIELD_LSB +: 3];
    end
  end

  // Count registers accept and ignore writes
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bvalid_q <= 1'b0;
      bresp_q <= usb_ep_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      unique case (awaddr_q)
        usb_ep_pkg::ADDR_ENDPOINT_SELECT,
        usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA,
        usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW,
        usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH: bresp_q <= usb_ep_pkg::RESP_OKAY;
        default: bresp_q <= usb_ep_pkg::RESP_SLVERR;
      endcase
    end else if (AXI_BREADY_IN) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign ar_take = AXI_ARVALID_IN & AXI_ARREADY_OUT;
  assign rd_block = (araddr_q == usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA) & rd_ep_ok &
                    (usb_push[rd_ep_q] | usb_pop[rd_ep_q]);
  assign sw_pop = (rd_state_q == usb_ep_pkg::RD_POP) & ~rd_block &
                  (araddr_q == usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA);
  assign AXI_ARREADY_OUT = (rd_state_q == usb_ep_pkg::RD_IDLE);
  assign AXI_RVALID_OUT = (rd_state_q == usb_ep_pkg::RD_RESP);
  assign AXI_RDATA_OUT = rdata_q;
  assign AXI_RRESP_OUT = rresp_q;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_state_q <= usb_ep_pkg::RD_IDLE;
      araddr_q <= 12'h000;
      rd_ep_q <= 3'h0;
      rd_empty_q <= 1'b1;
    end else begin
      unique case (rd_state_q)
        usb_ep_pkg::RD_IDLE: begin
          if (ar_take) begin
            araddr_q <= AXI_ARADDR_IN;
            rd_ep_q <= sel_q;
            rd_state_q <= usb_ep_pkg::RD_POP;
          end
        end
        usb_ep_pkg::RD_POP: begin
          if (!rd_block) begin
            rd_empty_q <= ~rd_ep_ok | fifo_empty[rd_ep_q];
            rd_state_q <= usb_ep_pkg::RD_LOAD;
          end
        end
        usb_ep_pkg::RD_LOAD: rd_state_q <= usb_ep_pkg::RD_RESP;
        usb_ep_pkg::RD_RESP: begin
          if (AXI_RREADY_IN) begin
            rd_state_q <= usb_ep_pkg::RD_IDLE;
          end
        end
        default: rd_state_q <= usb_ep_pkg::RD_IDLE;
      endcase
    end
  end

  // Empty FIFO reads as zero and leaves the pointer alone
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= usb_ep_pkg::RESP_OKAY;
    end else if (rd_state_q == usb_ep_pkg::RD_LOAD) begin
      rresp_q <= usb_ep_pkg::RESP_OKAY;
      unique case (araddr_q)
        usb_ep_pkg::ADDR_ENDPOINT_SELECT: rdata_q <= {29'h0, sel_q};
        usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA: rdata_q <= rd_empty_q ? 32'h0 : {24'h0, fifo_rdata_sel};
        usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW: rdata_q <= {24'h0, cnt_sel[7:0]};
        usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH: rdata_q <= {30'h0, cnt_sel[CNT_W-1 -: 2]};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= usb_ep_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_data_read_load;
    (rd_state_q == usb_ep_pkg::RD_LOAD) && (araddr_q == usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA) && !rd_empty_q;
  endsequence

  sequence s_response_up;
    AXI_RVALID_OUT ##0 (AXI_RRESP_OUT == usb_ep_pkg::RESP_OKAY);
  endsequence

  a_push_selected: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (sw_push && sel_ok && fifo_empty[sel_q]) |=> !fifo_empty[$past(sel_q)])
    else $error("data write missed the selected FIFO");
  a_read_returns: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_data_read_load |=> s_response_up ##0 (AXI_RDATA_OUT[7:0] == $past(fifo_rdata_sel)))
    else $error("data read returned the wrong byte");
  a_read_index: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ar_take |=> (rd_ep_q == $past(sel_q)) ##[1:2] (rd_state_q == usb_ep_pkg::RD_LOAD || rd_block))
    else $error("read not indexed by endpoint select");
  a_low_count: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_state_q == usb_ep_pkg::RD_LOAD && araddr_q == usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW)
    |=> AXI_RVALID_OUT && AXI_RDATA_OUT[7:0] == $past(cnt_sel[7:0])) else $error("low count mismatch");
  a_count_store: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (USB_RX_EOP_IN && rx_active_q) |=> cnt_q[$past(rx_ep_q)] == $past(rx_count))
    else $error("byte count not stored at end of packet");
  a_high_count: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (rd_state_q == usb_ep_pkg::RD_LOAD && araddr_q == usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH)
    |=> AXI_RDATA_OUT[1:0] == $past(cnt_sel[CNT_W-1 -: 2])) else $error("high count mismatch");
  a_reserved_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (AXI_RVALID_OUT && araddr_q == usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH) |-> AXI_RDATA_OUT[31:2] == 30'h0)
    else $error("reserved count bits not zero");
  a_pop_once: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    sw_pop |=> !sw_pop [*2]) else $error("one read popped more than one byte");
endmodule

// ==== src/usb_ep_pkg.sv ====
package usb_ep_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NUM_EP = 7;
  localparam int EP_W = 3;
  localparam int FIFO_DEPTH = 64;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Register indices and byte addresses (address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ENDPOINT_SELECT = 8'hc7;
  localparam logic [7:0] IDX_ENDPOINT_FIFO_DATA = 8'hcf;
  localparam logic [7:0] IDX_RX_BYTE_COUNT_LOW = 8'he2;
  localparam logic [7:0] IDX_RX_BYTE_COUNT_HIGH = 8'he3;
  localparam logic [11:0] ADDR_ENDPOINT_SELECT = {2'h0, IDX_ENDPOINT_SELECT, 2'h0};
  localparam logic [11:0] ADDR_ENDPOINT_FIFO_DATA = {2'h0, IDX_ENDPOINT_FIFO_DATA, 2'h0};
  localparam logic [11:0] ADDR_RX_BYTE_COUNT_LOW = {2'h0, IDX_RX_BYTE_COUNT_LOW, 2'h0};
  localparam logic [11:0] ADDR_RX_BYTE_COUNT_HIGH = {2'h0, IDX_RX_BYTE_COUNT_HIGH, 2'h0};

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int ENDPOINT_NUMBER_FIELD_LSB = 0;
  localparam int COUNT_LOW_BITS = 8;
  localparam int COUNT_HIGH_BITS = 2;
  localparam logic [2:0] ENDPOINT_SELECT_RESET = 3'h0;
  localparam logic [7:0] FIFO_DATA_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_POP = 4'h2,
    RD_LOAD = 4'h4,
    RD_RESP = 4'h8
  } rd_state_t;
endpackage

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic clk, rst;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rx_valid, rx_pid, rx_eop, tx_pop, tx_valid;
  logic [7:0] rx_data, tx_data;
  logic [2:0] rx_ep, tx_ep;
  logic [6:0] fifo_empty;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  typedef struct {logic [2:0] ep; int n; logic [7:0] lo; logic [1:0] hi;} row_t;
  row_t rows[4] = '{'{3'h0, 5, 8'h05, 2'h0}, '{3'h1, 0, 8'h00, 2'h0}, '{3'h3, 64, 8'h40, 2'h0},
    '{3'h6, 770, 8'h02, 2'h3}};

  usb_ep_access i_dut (.CLK_IN(clk), .RST_IN(rst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
    .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .USB_RX_VALID_IN(rx_valid),
    .USB_RX_PID_IN(rx_pid), .USB_RX_DATA_IN(rx_data), .USB_RX_EP_IN(rx_ep), .USB_RX_EOP_IN(rx_eop),
    .USB_TX_POP_IN(tx_pop), .USB_TX_EP_IN(tx_ep), .USB_TX_DATA_OUT(tx_data), .USB_TX_VALID_OUT(tx_valid),
    .USB_FIFO_EMPTY_OUT(fifo_empty));

  usb_host_model i_host (.clk_in(clk), .rx_valid_out(rx_valid), .rx_pid_out(rx_pid), .rx_data_out(rx_data),
    .rx_ep_out(rx_ep), .rx_eop_out(rx_eop), .tx_pop_out(tx_pop), .tx_ep_out(tx_ep), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid));

  // ------------------------------------------------------------
  // Clock, timeout, reporting
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about a thousand cycles; this leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: run hung", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Register bus master
  // ------------------------------------------------------------
  // Ready and valid are looked at on the falling edge, where they equal the next rising-edge value
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw) begin
        awvalid <= 1'b0;
      end
      if (w) begin
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar) begin
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic v;
    logic [7:0] b;
    int k;
    rst = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_SELECT, d, r);
    check(d, 32'h0);
    foreach (rows[i]) begin
      i_host.send_packet(rows[i].ep, rows[i].n, {rows[i].ep, 5'h0});
      axi_write(usb_ep_pkg::ADDR_ENDPOINT_SELECT, {29'h0, rows[i].ep}, r);
      check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_OKAY});
      axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW, d, r);
      check(d, {24'h0, rows[i].lo});
      check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_OKAY});
      axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH, d, r);
      check(d, {30'h0, rows[i].hi});
      k = (rows[i].n < 3) ? rows[i].n : 3;
      for (int j = 0; j < k; j++) begin
        axi_read(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, d, r);
        check(d, {24'h0, {rows[i].ep, 5'h0} + 8'(j)});
      end
    end
    // Back to endpoint 0: its own count and its pointer resume where they stood
    axi_write(usb_ep_pkg::ADDR_ENDPOINT_SELECT, 32'h0, r);
    axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW, d, r);
    check(d, 32'h5);
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, d, r);
    check(d, 32'h3);
    // Software fills endpoint 4 back to back, host drains it in order
    axi_write(usb_ep_pkg::ADDR_ENDPOINT_SELECT, 32'h4, r);
    for (int j = 0; j < 3; j++) begin
      axi_write(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, {24'h0, 8'ha1 + 8'(j)}, r);
      check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_OKAY});
    end
    check({31'h0, fifo_empty[4]}, 32'h0);
    for (int j = 0; j < 3; j++) begin
      i_host.pop_byte(3'h4, v, b);
      check({31'h0, v}, 32'h1);
      check({24'h0, b}, {24'h0, 8'ha1 + 8'(j)});
    end
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, d, r);
    check(d, 32'h0);
    // Write with byte lane 0 disabled leaves the FIFO untouched
    wstrb <= 4'h0;
    axi_write(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, 32'h77, r);
    check({31'h0, fifo_empty[4]}, 32'h1);
    wstrb <= 4'h1;
    // Code 7 names no endpoint: data and count read as zero
    axi_write(usb_ep_pkg::ADDR_ENDPOINT_SELECT, 32'h7, r);
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_FIFO_DATA, d, r);
    check(d, 32'h0);
    axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW, d, r);
    check(d, 32'h0);
    // High count register ignores writes; reserved bits stay clear
    axi_write(usb_ep_pkg::ADDR_ENDPOINT_SELECT, 32'h6, r);
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_SELECT, d, r);
    check(d, 32'h6);
    axi_write(usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH, 32'h0, r);
    check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_OKAY});
    axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_HIGH, d, r);
    check(d, 32'h3);
    axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW, d, r);
    check(d, 32'h2);
    // Unmapped places
    axi_read(12'h000, d, r);
    check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_SLVERR});
    check(d, 32'h0);
    axi_write(12'h004, 32'h0, r);
    check({30'h0, r}, {30'h0, usb_ep_pkg::RESP_SLVERR});
    // Reset in mid-run clears selection and counts
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_read(usb_ep_pkg::ADDR_ENDPOINT_SELECT, d, r);
    check(d, 32'h0);
    axi_read(usb_ep_pkg::ADDR_RX_BYTE_COUNT_LOW, d, r);
    check(d, 32'h0);
    final_report();
  end
endmodule

// ==== tb/usb_host_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far side of the endpoint link: packet source and IN drain
// ------------------------------------------------------------
module usb_host_model (
  input wire logic clk_in,
  output logic rx_valid_out,
  output logic rx_pid_out,
  output logic [7:0] rx_data_out,
  output logic [2:0] rx_ep_out,
  output logic rx_eop_out,
  output logic tx_pop_out,
  output logic [2:0] tx_ep_out,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in
);
  initial begin
    rx_valid_out = 1'b0;
    rx_pid_out = 1'b0;
    rx_data_out = 8'h5a;
    rx_ep_out = 3'h0;
    rx_eop_out = 1'b0;
    tx_pop_out = 1'b0;
    tx_ep_out = 3'h0;
  end

  // PID byte first, then n data bytes, then an idle cycle before the end marker
  task automatic send_packet(input logic [2:0] ep, input int n, input logic [7:0] base);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_pid_out <= 1'b1;
    rx_ep_out <= ep;
    rx_data_out <= 8'hc3;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      rx_pid_out <= 1'b0;
      rx_data_out <= base + 8'(i);
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_pid_out <= 1'b0;
    // Idle data line must not keep a plausible byte
    rx_data_out <= ~rx_data_out;
    @(posedge clk_in);
    rx_eop_out <= 1'b1;
    @(posedge clk_in);
    rx_eop_out <= 1'b0;
  endtask

  task automatic pop_byte(input logic [2:0] ep, output logic v, output logic [7:0] d);
    @(posedge clk_in);
    tx_pop_out <= 1'b1;
    tx_ep_out <= ep;
    @(posedge clk_in);
    tx_pop_out <= 1'b0;
    #1 v = tx_valid_in;
    @(posedge clk_in);
    #1 d = tx_data_in;
  endtask
endmodule
